// >>> core/rss_sequencer.sv
// power-up, configuration load and conversion-enable sequencer
`timescale 1ns/1ns
`include "rss_defines.svh"

module rss_sequencer
    import rss_pkg::*;
#(
    parameter int CFG_DEPTH = 16
)
(
    // clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   resetn_i,
    // asynchronous monitor pins
    input  wire logic                   bias_rail_ok_i,
    input  wire logic                   core_logic_rail_ok_i,
    input  wire logic                   osc_stable_i,
    input  wire logic                   enable_i,
    input  wire logic                   vin_ok_i,
    // nonvolatile config store read port
    output logic                        nvm_rd_o,
    output logic [`RSS_ADDR_W-1:0]      nvm_addr_o,
    input  wire logic                   nvm_valid_i,
    input  wire logic [`RSS_DATA_W-1:0] nvm_data_i,
    // working register write port
    output logic                        cfg_wr_o,
    output logic [`RSS_ADDR_W-1:0]      cfg_addr_o,
    output logic [`RSS_DATA_W-1:0]      cfg_data_o,
    // management bus writes
    input  wire logic                   mgmt_wr_i,
    input  wire logic [`RSS_ADDR_W-1:0] mgmt_addr_i,
    input  wire logic [`RSS_DATA_W-1:0] mgmt_data_i,
    output logic                        mgmt_ready_o,
    // address converter
    output logic                        adc_start_o,
    input  wire logic                   adc_done_i,
    input  wire logic [`RSS_ADC_W-1:0]  adc_code_i,
    output logic [`RSS_OFS_W-1:0]       addr_offset_o,
    output logic                        addr_valid_o,
    // status and conversion control
    output logic                        por_n_o,
    output logic                        load_done_o,
    output logic [`RSS_DATA_W-1:0]      freq_khz_o,
    output logic                        freq_reject_o,
    output logic                        freq_low_o,
    output logic                        conv_en_o
);

    // ----------------------------------------
    // checks and helpers
    // ----------------------------------------
    // depth must fit the store address, refused at elaboration
    if (CFG_DEPTH < 1 || CFG_DEPTH > (1 << `RSS_ADDR_W))
    begin
        $error("rss_sequencer: CFG_DEPTH out of range");
    end

    localparam logic [`RSS_ADDR_W-1:0] LAST_ADDR = `RSS_ADDR_W'(CFG_DEPTH - 1);

    // upper bits of the code give sixteen equal bins; resistor ladder is sized to match
    function automatic logic [`RSS_OFS_W-1:0] adc_to_offset(input logic [`RSS_ADC_W-1:0] code);
        adc_to_offset = code[`RSS_ADC_W-1 -: `RSS_OFS_W];
    endfunction

    function automatic logic freq_ok(input logic [`RSS_DATA_W-1:0] khz);
        freq_ok = (khz >= `RSS_FREQ_MIN_KHZ) && (khz <= `RSS_FREQ_MAX_KHZ);
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    rss_regs_t r_ff;
    rss_regs_t nxt_r;
    logic      por_in;
    logic      ready;
    logic      hw_gate;
    logic      wr_req;
    rss_wr_t   wr;

    always_comb
    begin
        nxt_r           = r_ff;
        nxt_r.sync1     = '{bias_rail_ok_i, core_logic_rail_ok_i, osc_stable_i, enable_i, vin_ok_i};
        nxt_r.sync2     = r_ff.sync1;
        nxt_r.nvm_rd    = 1'b0;
        nxt_r.cfg_wr    = 1'b0;
        nxt_r.adc_start = 1'b0;
        nxt_r.freq_rej  = 1'b0;
        wr_req          = 1'b0;
        wr              = '0;
        por_in          = r_ff.sync2.bias_ok & r_ff.sync2.core_ok & r_ff.sync2.osc_ok;
        nxt_r.por_ok    = por_in;
        if (!por_in)
        begin
            nxt_r.st         = RSS_S_POR;
            nxt_r.load_done  = 1'b0;
            nxt_r.addr_valid = 1'b0;
            nxt_r.nvm_addr   = '0;
        end
        else
        begin
            case (r_ff.st)
                RSS_S_POR:
                begin
                    nxt_r.st       = RSS_S_LOAD_REQ;
                    nxt_r.nvm_addr = '0;
                end
                RSS_S_LOAD_REQ:
                begin
                    nxt_r.nvm_rd = 1'b1;
                    nxt_r.st     = RSS_S_LOAD_WAIT;
                end
                RSS_S_LOAD_WAIT:
                begin
                    if (nvm_valid_i)
                    begin
                        wr_req = 1'b1;
                        wr     = '{r_ff.nvm_addr, nvm_data_i};
                        if (r_ff.nvm_addr == LAST_ADDR)
                        begin
                            nxt_r.load_done = 1'b1;
                            nxt_r.st        = RSS_S_ADC_REQ;
                        end
                        else
                        begin
                            nxt_r.nvm_addr = r_ff.nvm_addr + `RSS_ADDR_W'(1);
                            nxt_r.st       = RSS_S_LOAD_REQ;
                        end
                    end
                end
                RSS_S_ADC_REQ:
                begin
                    nxt_r.adc_start = 1'b1;
                    nxt_r.st        = RSS_S_ADC_WAIT;
                end
                RSS_S_ADC_WAIT:
                begin
                    if (adc_done_i)
                    begin
                        nxt_r.addr_off   = adc_to_offset(adc_code_i);
                        nxt_r.addr_valid = 1'b1;
                        nxt_r.st         = RSS_S_RUN;
                    end
                end
                RSS_S_RUN:
                begin
                    nxt_r.st = RSS_S_RUN;
                end
                default:
                begin
                    nxt_r.st = RSS_S_POR;
                end
            endcase
            // bus writes only after load, so they never collide with store writes
            if (r_ff.load_done && mgmt_wr_i && !wr_req)
            begin
                wr_req = 1'b1;
                wr     = '{mgmt_addr_i, mgmt_data_i};
            end
        end
        if (wr_req)
        begin
            nxt_r.cfg_wr = 1'b1;
            nxt_r.cfg    = wr;
            if (wr.addr == `RSS_CTRL_ADDR)
            begin
                case (wr.data[`RSS_MODE_MSB:`RSS_MODE_LSB])
                    2'h1:    nxt_r.mode = RSS_EN_SW;
                    2'h2:    nxt_r.mode = RSS_EN_HW_AND_SW;
                    default: nxt_r.mode = RSS_EN_HW;
                endcase
                nxt_r.sw_on = wr.data[`RSS_SWON_BIT];
            end
            if (wr.addr == `RSS_FREQ_ADDR)
            begin
                if (freq_ok(wr.data))
                begin
                    nxt_r.freq     = wr.data;
                    nxt_r.freq_low = (wr.data < `RSS_FREQ_REC_KHZ);
                end
                else
                begin
                    nxt_r.freq_rej = 1'b1;
                end
            end
        end
        // ready and the gates of the current mode are re-checked each cycle; in RSS_EN_SW mode losing enable or vin_ok does not drop the output
        ready   = por_in && r_ff.load_done && r_ff.addr_valid;
        hw_gate = r_ff.sync2.enable && r_ff.sync2.vin_ok;
        case (r_ff.mode)
            RSS_EN_SW:        nxt_r.conv_en = ready && r_ff.sw_on;
            RSS_EN_HW_AND_SW: nxt_r.conv_en = ready && hw_gate && r_ff.sw_on;
            default:          nxt_r.conv_en = ready && hw_gate;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            r_ff <= '0;
        else
            r_ff <= nxt_r;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign nvm_rd_o      = r_ff.nvm_rd;
    assign nvm_addr_o    = r_ff.nvm_addr;
    assign cfg_wr_o      = r_ff.cfg_wr;
    assign cfg_addr_o    = r_ff.cfg.addr;
    assign cfg_data_o    = r_ff.cfg.data;
    assign mgmt_ready_o  = r_ff.load_done;
    assign adc_start_o   = r_ff.adc_start;
    assign addr_offset_o = r_ff.addr_off;
    assign addr_valid_o  = r_ff.addr_valid;
    assign por_n_o       = r_ff.por_ok;
    assign load_done_o   = r_ff.load_done;
    assign freq_khz_o    = r_ff.freq;
    assign freq_reject_o = r_ff.freq_rej;
    assign freq_low_o    = r_ff.freq_low;
    assign conv_en_o     = r_ff.conv_en;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    por_hold_a: assert property (!(r_ff.sync2.bias_ok && r_ff.sync2.core_ok && r_ff.sync2.osc_ok)
        |=> !por_n_o && !load_done_o && !conv_en_o)
        else $error("reset released without good rails and oscillator");
    load_start_a: assert property ($rose(por_n_o) |=> nvm_rd_o && nvm_addr_o == '0)
        else $error("load did not start at word zero");
    load_last_a: assert property ($rose(load_done_o) |-> cfg_wr_o && cfg_addr_o == LAST_ADDR)
        else $error("load ended before last word");
    mgmt_accept_a: assert property (load_done_o && por_in && mgmt_wr_i && !nvm_valid_i
        |=> cfg_wr_o && cfg_addr_o == $past(mgmt_addr_i) && cfg_data_o == $past(mgmt_data_i))
        else $error("bus write after load not passed on");
    conv_ready_a: assert property (conv_en_o |-> load_done_o && addr_valid_o && por_n_o)
        else $error("conversion enabled before load and address");
    hw_drop_a: assert property (r_ff.mode == RSS_EN_HW && !(r_ff.sync2.enable && r_ff.sync2.vin_ok)
        |=> !conv_en_o)
        else $error("conversion not dropped when a gate failed");
    sw_mode_a: assert property (r_ff.mode == RSS_EN_SW && r_ff.sw_on && load_done_o && addr_valid_o
        && por_in |=> conv_en_o)
        else $error("software enable ignored");
    freq_take_a: assert property (cfg_wr_o && cfg_addr_o == `RSS_FREQ_ADDR
        |-> (freq_ok(cfg_data_o) ? freq_khz_o == cfg_data_o && !freq_reject_o
                                 : freq_reject_o))
        else $error("frequency write handled wrongly");
    addr_read_a: assert property ($rose(addr_valid_o) |-> addr_offset_o == adc_to_offset($past(adc_code_i))
        && $past(adc_done_i))
        else $error("address offset not taken from converter");

    load_done_c: cover property ($rose(load_done_o));
    conv_on_c:   cover property ($rose(conv_en_o));
    conv_drop_c: cover property ($fell(conv_en_o) ##[1:20] conv_en_o);
    freq_rej_c:  cover property (freq_reject_o);

endmodule

// >>> core/rss_defines.svh
// widths, offsets, field positions and limits of the regulator startup sequencer
`ifndef RSS_DEFINES_SVH
`define RSS_DEFINES_SVH

`define RSS_ADDR_W        8
`define RSS_DATA_W        16
`define RSS_ADC_W         10
`define RSS_OFS_W         4
`define RSS_CTRL_ADDR     8'h00
`define RSS_FREQ_ADDR     8'h01
`define RSS_MODE_LSB      0
`define RSS_MODE_MSB      1
`define RSS_SWON_BIT      2
`define RSS_FREQ_MIN_KHZ  16'h0096
`define RSS_FREQ_MAX_KHZ  16'h05DC
`define RSS_FREQ_REC_KHZ  16'h01F4
`define RSS_OSC_MHZ       48

`endif

// >>> core/rss_pkg.sv
// types of the regulator startup sequencer
`include "rss_defines.svh"

package rss_pkg;

    typedef enum logic [2:0] {
        RSS_S_POR,
        RSS_S_LOAD_REQ,
        RSS_S_LOAD_WAIT,
        RSS_S_ADC_REQ,
        RSS_S_ADC_WAIT,
        RSS_S_RUN
    } rss_state_t;

    typedef enum logic [1:0] {
        RSS_EN_HW,
        RSS_EN_SW,
        RSS_EN_HW_AND_SW
    } rss_en_mode_t;

    // synchronised pins, msb first: bias, core, osc, enable, vin
    typedef struct packed {
        logic bias_ok;
        logic core_ok;
        logic osc_ok;
        logic enable;
        logic vin_ok;
    } rss_pins_t;

    typedef struct packed {
        logic [`RSS_ADDR_W-1:0] addr;
        logic [`RSS_DATA_W-1:0] data;
    } rss_wr_t;

    typedef struct packed {
        rss_pins_t              sync1;
        rss_pins_t              sync2;
        rss_state_t             st;
        logic [`RSS_ADDR_W-1:0] nvm_addr;
        logic                   nvm_rd;
        logic                   cfg_wr;
        rss_wr_t                cfg;
        logic                   adc_start;
        logic [`RSS_OFS_W-1:0]  addr_off;
        logic                   addr_valid;
        logic                   load_done;
        logic                   por_ok;
        rss_en_mode_t           mode;
        logic                   sw_on;
        logic [`RSS_DATA_W-1:0] freq;
        logic                   freq_rej;
        logic                   freq_low;
        logic                   conv_en;
    } rss_regs_t;

endpackage

// >>> tb/rss_partner_model.sv
// store and address converter model for the startup sequencer bench
`timescale 1ns/1ns

module rss_partner_model
#(
    parameter logic [9:0] ADC_CODE = 10'h155
)
(
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    // store read port
    input  wire logic        nvm_rd_i,
    input  wire logic [7:0]  nvm_addr_i,
    output logic             nvm_valid_o,
    output logic [15:0]      nvm_data_o,
    // address converter
    input  wire logic        adc_start_i,
    output logic             adc_done_o,
    output logic [9:0]       adc_code_o
);
    // ----------
    // answers
    // ----------
    logic [7:0] addr_ff;
    logic [1:0] wait_ff;
    logic       busy_ff;
    logic [1:0] adc_ff;

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            {addr_ff, wait_ff, busy_ff, adc_ff} <= '0;
            {nvm_valid_o, nvm_data_o, adc_done_o, adc_code_o} <= '0;
        end
        else
        begin
            // released lines toggle so stale data never looks valid
            nvm_valid_o <= 1'b0;
            nvm_data_o  <= ~nvm_data_o;
            adc_done_o  <= 1'b0;
            adc_code_o  <= ~adc_code_o;
            if (nvm_rd_i)
            begin
                busy_ff <= 1'b1;
                addr_ff <= nvm_addr_i;
                wait_ff <= {nvm_addr_i[0], 1'b0}; // odd words answer slowly
            end
            else if (busy_ff && wait_ff != 2'h0)
                wait_ff <= wait_ff - 2'h1;
            else if (busy_ff)
            begin
                busy_ff     <= 1'b0;
                nvm_valid_o <= 1'b1;
                nvm_data_o  <= (addr_ff == 8'h01) ? 16'h0258 : {8'h5A, addr_ff};
            end
            if (adc_start_i)
                adc_ff <= 2'h3;
            else if (adc_ff != 2'h0)
                adc_ff <= adc_ff - 2'h1;
            if (adc_ff == 2'h1)
            begin
                adc_done_o <= 1'b1;
                adc_code_o <= ADC_CODE;
            end
        end
    end
endmodule

// >>> tb/test_regulator_startup_sequencer.sv
// self-checking bench for the regulator startup sequencer
`timescale 1ns/1ns
`include "rss_defines.svh"

module test_regulator_startup_sequencer;
    // ----------
    // wiring
    // ----------
    localparam int         DEPTH = 4;
    localparam logic [9:0] CODE  = 10'h2C5;
    logic               sys_clk_i   = 1'b0;
    logic               resetn_i    = 1'b0;
    rss_pkg::rss_pins_t pins        = '0;
    rss_pkg::rss_wr_t   mreq        = '0;
    logic               mwr         = 1'b0;
    logic               nvm_rd, nvm_valid, cfg_wr, ready, adc_start, adc_done, avalid, por_n, ldone, frej, flow, conv;
    logic [7:0]         nvm_addr, cfg_addr;
    logic [15:0]        nvm_data, cfg_data, freq;
    logic [9:0]         adc_code;
    logic [3:0]         aofs;
    int                 error_cnt   = 0;
    int                 comparisons = 0;

    always #5 sys_clk_i = ~sys_clk_i;

    rss_sequencer #(.CFG_DEPTH(DEPTH)) DUT (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .bias_rail_ok_i(pins.bias_ok), .core_logic_rail_ok_i(pins.core_ok), .osc_stable_i(pins.osc_ok),
        .enable_i(pins.enable), .vin_ok_i(pins.vin_ok), .nvm_rd_o(nvm_rd), .nvm_addr_o(nvm_addr),
        .nvm_valid_i(nvm_valid), .nvm_data_i(nvm_data), .cfg_wr_o(cfg_wr), .cfg_addr_o(cfg_addr),
        .cfg_data_o(cfg_data), .mgmt_wr_i(mwr), .mgmt_addr_i(mreq.addr), .mgmt_data_i(mreq.data),
        .mgmt_ready_o(ready), .adc_start_o(adc_start), .adc_done_i(adc_done), .adc_code_i(adc_code),
        .addr_offset_o(aofs), .addr_valid_o(avalid), .por_n_o(por_n), .load_done_o(ldone),
        .freq_khz_o(freq), .freq_reject_o(frej), .freq_low_o(flow), .conv_en_o(conv));

    rss_partner_model #(.ADC_CODE(CODE)) far (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .nvm_rd_i(nvm_rd), .nvm_addr_i(nvm_addr), .nvm_valid_o(nvm_valid), .nvm_data_o(nvm_data),
        .adc_start_i(adc_start), .adc_done_o(adc_done), .adc_code_o(adc_code));

    // ----------
    // helpers
    // ----------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic setpins(input logic [4:0] v, input int n);
        @(posedge sys_clk_i);
        pins <= v;
        tick(n);
    endtask

    task automatic mw(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        mwr  <= 1'b1;
        mreq <= {a, d};
        @(posedge sys_clk_i);
        mwr <= 1'b0;
        #1;
        if (a == `RSS_CTRL_ADDR)
        begin
            chk("cfg_wr", cfg_wr, 1'b1);
            chk("cfg_data", cfg_data, d);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----------
    // scenarios
    // ----------
    task automatic t_por_load();
        int k;
        // writes before the load must be dropped
        mw(8'h01, 16'h03E8);
        chk("cfg_wr", cfg_wr, 1'b0);
        setpins(5'b11011, 8);
        chk("por_n", por_n, 1'b0);
        setpins(5'b11111, 2);
        chk("por_n", por_n, 1'b0);
        tick(1);
        chk("por_n", por_n, 1'b1);
        tick(1);
        chk("nvm_rd", nvm_rd, 1'b1);
        chk("nvm_addr", nvm_addr, 16'h0000);
        for (int i = 0; i < DEPTH; i++)
        begin
            for (k = 0; k < 20 && cfg_wr !== 1'b1; k++)
                tick(1);
            chk("cfg_addr", cfg_addr, 16'(i));
            chk("cfg_data", cfg_data, (i == 1) ? 16'h0258 : {8'h5A, 8'(i)});
            chk("load_done", ldone, i == DEPTH - 1);
            chk("conv_en", conv, 1'b0);
            tick(1);
        end
        chk("mgmt_ready", ready, 1'b1);
        chk("freq_khz", freq, 16'h0258);
        for (k = 0; k < 20 && avalid !== 1'b1; k++)
            tick(1);
        chk("addr_valid", avalid, 1'b1);
        chk("addr_offset", aofs, CODE[9:6]);
    endtask

    task automatic t_gate();
        setpins(5'b11101, 4);
        chk("conv_en", conv, 1'b0);
        setpins(5'b11111, 4);
        chk("conv_en", conv, 1'b1);
        setpins(5'b11110, 4);
        chk("conv_en", conv, 1'b0);
        setpins(5'b11111, 4);
        chk("conv_en", conv, 1'b1);
    endtask

    task automatic t_modes_freq();
        logic [15:0] fv [6] = '{16'h0095, 16'h0096, 16'h05DC, 16'h05DD, 16'h01F3, 16'h01F4};
        logic [15:0] ef = 16'h0258;
        logic        acc;
        for (int m = 0; m < 4; m++)
            for (int s = 0; s < 2; s++)
                for (int e = 0; e < 2; e++)
                begin
                    setpins({3'b111, e[0], 1'b1}, 1);
                    mw(`RSS_CTRL_ADDR, 16'(s * 4 + m));
                    tick(4);
                    chk("conv_en", conv, (m == 1) ? s[0] : (m == 2) ? (e[0] & s[0]) : e[0]);
                end
        for (int i = 0; i < 6; i++)
        begin
            mw(`RSS_FREQ_ADDR, fv[i]);
            acc = fv[i] >= `RSS_FREQ_MIN_KHZ && fv[i] <= `RSS_FREQ_MAX_KHZ;
            ef  = acc ? fv[i] : ef;
            chk("freq_reject", frej, !acc);
            chk("freq_khz", freq, ef);
            chk("freq_low", flow, ef < `RSS_FREQ_REC_KHZ);
        end
        // losing a rail drops por_n, load_done and conv_en
        setpins(5'b10111, 4);
        chk("por_n", por_n, 1'b0);
        chk("conv_en", conv, 1'b0);
        chk("load_done", ldone, 1'b0);
    endtask

    initial
    begin
        repeat (2) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        t_por_load();
        t_gate();
        t_modes_freq();
        finish_test();
    end

    initial
    begin
        repeat (5000) @(posedge sys_clk_i);
        error_cnt++;
        finish_test();
    end
endmodule
